/* File: core/tcs_pkg.sv */
// Package for the thyristor current switch-over logic: constants and carrier types.
// Assumes a 40 MHz clock; setpoints are signed fixed-point words with 1.0 = 16'h1000.
package tcs_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ              = 40000000;
  localparam int unsigned SAMPLE_INTERVAL_MS  = 0;     // Sampling interval setting default
  localparam int unsigned ZERO_TORQUE_TIME_MS = 2000;  // Zero-torque monitoring time default
  localparam int unsigned MS_CYCLES           = CLK_HZ / 1000;
  localparam int unsigned ZERO_TORQUE_CYCLES  = ZERO_TORQUE_TIME_MS * MS_CYCLES;

  // Register bus map (word offsets are byte addresses / 4)
  localparam logic [3:0] REG_CTRL      = 4'h0;  // Bit0 switch on, bit1 acknowledge, bit2 test mode, bit3 suppress
  localparam logic [3:0] REG_CMD       = 4'h1;  // Bit0 on1, bit1 off1, bit2 on2, bit3 off2
  localparam logic [3:0] REG_INHIB1    = 4'h2;
  localparam logic [3:0] REG_INHIB2    = 4'h3;
  localparam logic [3:0] REG_SUPPRESS  = 4'h4;
  localparam logic [3:0] REG_FEN1      = 4'h5;
  localparam logic [3:0] REG_FEN2      = 4'h6;
  localparam logic [3:0] REG_HWEN      = 4'h7;
  localparam logic [3:0] REG_THRESH    = 4'h8;
  localparam logic [3:0] REG_STOPST    = 4'h9;
  localparam logic [3:0] REG_SAMPLE    = 4'ha;  // Interval in ms
  localparam logic [3:0] REG_STATUS    = 4'hb;  // Read only: control word
  localparam logic [3:0] REG_FAULTS    = 4'hc;  // Read only: fault word two : fault word one
  localparam logic [3:0] REG_DIAG      = 4'hd;  // Read only: irq, next, present, previous

  // Reset values
  localparam logic [15:0] INHIB_RST    = 16'h0000;
  localparam logic [15:0] SUPPRESS_RST = 16'h067e;
  localparam logic [15:0] FEN_RST      = 16'hffff;
  localparam logic [15:0] HWEN_RST     = 16'hffff;
  localparam logic [15:0] THRESH_RST   = 16'h0029;  // About 0.01 in 1.0 = 16'h1000 scaling
  localparam logic [7:0]  STOPST_RST   = 8'h64;     // State one hundred
  localparam logic [15:0] SAMPLE_RST   = 16'h0000;

  // Control word bit positions (bit 1 of the word is index 0)
  localparam int unsigned CW_ON = 0;
  localparam int unsigned CW_PI = 1;
  localparam int unsigned CW_PS = 2;
  localparam int unsigned CW_CE = 3;
  localparam int unsigned CW_D1 = 4;
  localparam int unsigned CW_D2 = 5;
  localparam int unsigned CW_SC = 6;
  localparam int unsigned CW_TM = 7;
  localparam int unsigned CW_M0 = 8;
  localparam int unsigned CW_M1 = 9;
  localparam int unsigned CW_M2 = 10;

  // State numbers shown on the diagnostic outputs
  localparam logic [7:0] ST_NUM_OFF  = 8'h01;
  localparam logic [7:0] ST_NUM_WAIT = 8'h02;
  localparam logic [7:0] ST_NUM_RUN1 = 8'h0b;
  localparam logic [7:0] ST_NUM_RUN2 = 8'h0c;
  localparam logic [7:0] ST_NUM_FLT  = 8'h1e;
  localparam logic [7:0] ST_NUM_IDLE = 8'h01;
  localparam logic [7:0] ST_NUM_INH  = 8'h02;

  typedef enum {ST_OFF, ST_WAIT, ST_RUN1, ST_RUN2, ST_FAULT} tcs_state_t;

  // Neighbouring block inputs
  typedef struct packed {
    logic [15:0] alarm_word_one;
    logic [15:0] alarm_word_two;
    logic [15:0] hw_raw;
    logic [15:0] setpoint_one;
    logic [15:0] setpoint_two;
    logic [15:0] controller_setting_value;
  } tcs_in_t;

  // Diagnostic state numbers
  typedef struct packed {
    logic [7:0] irq;
    logic [7:0] next;
    logic [7:0] present;
    logic [7:0] prev;
  } tcs_diag_t;

endpackage : tcs_pkg

/* File: core/tcs_switchover.sv */
// Switch-over and fault logic of a thyristor current loop, with an Avalon-MM register slave.
// Assumes inputs synchronous to CLK, a 32-bit Avalon master honouring waitrequest.
//
// Implementation choices: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
module tcs_switchover #(
  parameter int unsigned ZT_CYCLES = tcs_pkg::ZERO_TORQUE_CYCLES,
  parameter int unsigned MS_CNT    = tcs_pkg::MS_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              CE,
  // Avalon-MM slave
  input  wire logic [5:0]        AVS_ADDRESS,
  input  wire logic              AVS_READ,
  input  wire logic              AVS_WRITE,
  input  wire logic [31:0]       AVS_WRITEDATA,
  input  wire logic [3:0]        AVS_BYTEENABLE,
  output logic      [31:0]       AVS_READDATA,
  output logic                   AVS_WAITREQUEST,
  // Neighbouring blocks
  input  wire tcs_pkg::tcs_in_t  IN_WORDS,
  // Controller and firing-block outputs
  output logic                   CONTROL_IN_OPERATION,
  output logic                   PULSE_INHIBIT_OUT,
  output logic                   INVERTER_SHIFT_OUT,
  output logic                   CONTROLLER_ENABLE_OUT,
  output logic                   CONTROLLER_SET_TRACK_OUT,
  output logic                   DIRECTION_ONE_OPERATIONAL,
  output logic                   DIRECTION_TWO_OPERATIONAL,
  output logic                   TEST_MODE_ACTIVE,
  output logic                   ZERO_TORQUE_REQUESTED,
  output logic                   DIRECTION_ONE_REQUESTED,
  output logic                   DIRECTION_TWO_REQUESTED,
  output logic      [15:0]       FIRING_CONTROL_WORD,
  output logic      [15:0]       SETPOINT_OUT,
  output logic      [15:0]       CONTROLLER_SETTING_VALUE,
  // Fault and diagnostic outputs
  output logic      [15:0]       HW_MESSAGE_WORD,
  output logic      [15:0]       ALARM_WORD_ONE,
  output logic      [15:0]       ALARM_WORD_TWO,
  output logic                   ALARM_SUMMARY,
  output logic      [15:0]       FAULT_WORD_ONE,
  output logic      [15:0]       FAULT_WORD_TWO,
  output logic                   FAULT_SUMMARY,
  output tcs_pkg::tcs_diag_t     DIAG
);
  import tcs_pkg::*;

  // Absolute value of a signed setpoint word
  function automatic logic [16:0] mag(input logic [16:0] v);
    mag = v[16] ? 17'(-v) : v;
  endfunction : mag

  // Map state to its diagnostic number
  function automatic logic [7:0] st_num(input tcs_state_t s);
    unique case (s)
      ST_OFF:   st_num = ST_NUM_OFF;
      ST_WAIT:  st_num = ST_NUM_WAIT;
      ST_RUN1:  st_num = ST_NUM_RUN1;
      ST_RUN2:  st_num = ST_NUM_RUN2;
      ST_FAULT: st_num = ST_NUM_FLT;
    endcase
  endfunction : st_num

  // Software registers
  logic        switch_on_q, ack_q, test_q, suppress_q;
  logic [3:0]  cmd_q;
  logic [15:0] inhib1_q, inhib2_q, group_q, fen1_q, fen2_q, hwen_q, thresh_q, sample_q;
  logic [7:0]  stop_q;

  // Bus slave: one wait cycle, answer on the second cycle
  logic        acc_q;
  logic [3:0]  idx;
  logic        wr_hit;
  assign idx    = AVS_ADDRESS[5:2];
  assign wr_hit = AVS_WRITE && acc_q && CE;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc_q           <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else if (CE) begin
      acc_q           <= (AVS_READ || AVS_WRITE) && !acc_q;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !acc_q);
      if (AVS_READ && !acc_q) begin
        unique case (idx)
          REG_CTRL:     AVS_READDATA <= {28'h0000000, suppress_q, test_q, ack_q, switch_on_q};
          REG_CMD:      AVS_READDATA <= {28'h0000000, cmd_q};
          REG_INHIB1:   AVS_READDATA <= {16'h0000, inhib1_q};
          REG_INHIB2:   AVS_READDATA <= {16'h0000, inhib2_q};
          REG_SUPPRESS: AVS_READDATA <= {16'h0000, group_q};
          REG_FEN1:     AVS_READDATA <= {16'h0000, fen1_q};
          REG_FEN2:     AVS_READDATA <= {16'h0000, fen2_q};
          REG_HWEN:     AVS_READDATA <= {16'h0000, hwen_q};
          REG_THRESH:   AVS_READDATA <= {16'h0000, thresh_q};
          REG_STOPST:   AVS_READDATA <= {24'h000000, stop_q};
          REG_SAMPLE:   AVS_READDATA <= {16'h0000, sample_q};
          REG_STATUS:   AVS_READDATA <= {16'h0000, FIRING_CONTROL_WORD};
          REG_FAULTS:   AVS_READDATA <= {FAULT_WORD_TWO, FAULT_WORD_ONE};
          REG_DIAG:     AVS_READDATA <= DIAG;
          default:      AVS_READDATA <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Register writes (low two byte lanes hold all fields)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      switch_on_q <= 1'b0;
      ack_q       <= 1'b0;
      test_q      <= 1'b0;
      suppress_q  <= 1'b0;
      cmd_q       <= 4'h0;
      inhib1_q    <= INHIB_RST;
      inhib2_q    <= INHIB_RST;
      group_q     <= SUPPRESS_RST;
      fen1_q      <= FEN_RST;
      fen2_q      <= FEN_RST;
      hwen_q      <= HWEN_RST;
      thresh_q    <= THRESH_RST;
      stop_q      <= STOPST_RST;
      sample_q    <= SAMPLE_RST;
    end else if (wr_hit) begin
      if (AVS_BYTEENABLE[0]) begin
        unique case (idx)
          REG_CTRL:     {suppress_q, test_q, ack_q, switch_on_q} <= AVS_WRITEDATA[3:0];
          REG_CMD:      cmd_q <= AVS_WRITEDATA[3:0];
          REG_INHIB1:   inhib1_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_INHIB2:   inhib2_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_SUPPRESS: group_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_FEN1:     fen1_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_FEN2:     fen2_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_HWEN:     hwen_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_THRESH:   thresh_q[7:0] <= AVS_WRITEDATA[7:0];
          REG_STOPST:   stop_q <= AVS_WRITEDATA[7:0];
          REG_SAMPLE:   sample_q[7:0] <= AVS_WRITEDATA[7:0];
          default:      ;
        endcase
      end
      if (AVS_BYTEENABLE[1]) begin
        unique case (idx)
          REG_INHIB1:   inhib1_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_INHIB2:   inhib2_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_SUPPRESS: group_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_FEN1:     fen1_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_FEN2:     fen2_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_HWEN:     hwen_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_THRESH:   thresh_q[15:8] <= AVS_WRITEDATA[15:8];
          REG_SAMPLE:   sample_q[15:8] <= AVS_WRITEDATA[15:8];
          default:      ;
        endcase
      end
    end
  end

  // Sampling tick: every clock when interval is zero, else every interval in ms
  logic [15:0] ms_cnt_q, ivl_cnt_q;
  logic        tick;
  assign tick = CE && ((sample_q == 16'h0000) || (ms_cnt_q == 16'(MS_CNT - 1) && ivl_cnt_q == sample_q - 16'h0001));

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ms_cnt_q  <= 16'h0000;
      ivl_cnt_q <= 16'h0000;
    end else if (CE) begin
      if (sample_q == 16'h0000 || tick) begin
        ms_cnt_q  <= 16'h0000;
        ivl_cnt_q <= 16'h0000;
      end else if (ms_cnt_q == 16'(MS_CNT - 1)) begin
        ms_cnt_q  <= 16'h0000;
        ivl_cnt_q <= ivl_cnt_q + 16'h0001;
      end else begin
        ms_cnt_q <= ms_cnt_q + 16'h0001;
      end
    end
  end

  // Masked words computed from this tick's inputs
  logic [15:0] hw_d, alarm1_d, fault1_d, fault2_d;
  logic        inhibit_now, fault_any;
  logic [16:0] sum_sp;
  logic        above, d1_req, d2_req, contradict;
  assign hw_d        = IN_WORDS.hw_raw & hwen_q & (suppress_q ? ~group_q : 16'hffff);
  assign alarm1_d    = IN_WORDS.alarm_word_one & (suppress_q ? ~group_q : 16'hffff);
  assign fault1_d    = alarm1_d & fen1_q;
  assign fault2_d    = IN_WORDS.alarm_word_two & fen2_q;
  assign inhibit_now = |(fault1_d & inhib1_q) || |(fault2_d & inhib2_q);
  assign fault_any   = |fault1_d || |fault2_d;
  assign sum_sp      = {IN_WORDS.setpoint_one[15], IN_WORDS.setpoint_one}
                     + {IN_WORDS.setpoint_two[15], IN_WORDS.setpoint_two};
  assign above       = mag(sum_sp) > {1'b0, thresh_q};
  assign d1_req      = above && !sum_sp[16];
  assign d2_req      = above && sum_sp[16];
  assign contradict  = (cmd_q[0] && cmd_q[1]) || (cmd_q[2] && cmd_q[3]);

  // Word outputs, once per tick
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      HW_MESSAGE_WORD <= 16'h0000;
      ALARM_WORD_ONE  <= 16'h0000;
      ALARM_WORD_TWO  <= 16'h0000;
      FAULT_WORD_ONE  <= 16'h0000;
      FAULT_WORD_TWO  <= 16'h0000;
      ALARM_SUMMARY   <= 1'b0;
      FAULT_SUMMARY   <= 1'b0;
    end else if (tick) begin
      HW_MESSAGE_WORD <= hw_d;
      ALARM_WORD_ONE  <= alarm1_d;
      ALARM_WORD_TWO  <= IN_WORDS.alarm_word_two;
      FAULT_WORD_ONE  <= fault1_d;
      FAULT_WORD_TWO  <= fault2_d;
      ALARM_SUMMARY   <= |alarm1_d || |IN_WORDS.alarm_word_two;
      FAULT_SUMMARY   <= fault_any;
    end
  end

  // Restart qualification: fault latched until cleared, acknowledged and switched on anew
  logic flt_q, acked_q, on_prev_q, ack_prev_q;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      flt_q      <= 1'b0;
      acked_q    <= 1'b0;
      on_prev_q  <= 1'b0;
      ack_prev_q <= 1'b0;
    end else if (tick) begin
      on_prev_q  <= switch_on_q;
      ack_prev_q <= ack_q;
      if (fault_any || contradict) begin
        flt_q   <= 1'b1;
        acked_q <= 1'b0;
      end else if (ack_q && !ack_prev_q && !switch_on_q) begin
        acked_q <= 1'b1;
      end else if (acked_q && switch_on_q && !on_prev_q) begin
        flt_q   <= 1'b0;
        acked_q <= 1'b0;
      end
    end
  end

  // Control state machine with diagnostic stop
  tcs_state_t state_q, state_d;
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_OFF:   state_d = switch_on_q && !flt_q ? ST_WAIT : ST_OFF;
      ST_WAIT:  state_d = !switch_on_q ? ST_OFF : d1_req ? ST_RUN1 : d2_req ? ST_RUN2 : ST_WAIT;
      ST_RUN1,
      ST_RUN2:  state_d = !switch_on_q ? ST_OFF : !above ? ST_WAIT
                        : (d1_req ? ST_RUN1 : ST_RUN2);
      ST_FAULT: state_d = !flt_q ? ST_OFF : ST_FAULT;
    endcase
    if (fault_any || contradict || flt_q) state_d = ST_FAULT;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_q <= ST_OFF;
      DIAG    <= '0;
    end else if (tick) begin
      DIAG.next <= st_num(state_d);
      DIAG.irq  <= inhibit_now ? ST_NUM_INH : ST_NUM_IDLE;
      if (st_num(state_q) != stop_q) begin
        state_q      <= state_d;
        DIAG.prev    <= st_num(state_q);
        DIAG.present <= st_num(state_d);
      end
    end
  end

  // Operating and firing outputs
  logic run, d1, d2, zero_cnt_hit;
  logic [31:0] zt_cnt_q;
  assign run = (state_d == ST_RUN1 || state_d == ST_RUN2);
  assign d1  = state_d == ST_RUN1;
  assign d2  = state_d == ST_RUN2;
  assign zero_cnt_hit = zt_cnt_q >= ZT_CYCLES;

  // Zero-torque monitor counts cycles with setpoint inside the threshold
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) zt_cnt_q <= 32'h0000_0000;
    else if (CE) begin
      if (above) zt_cnt_q <= 32'h0000_0000;
      else if (!zero_cnt_hit) zt_cnt_q <= zt_cnt_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CONTROL_IN_OPERATION      <= 1'b0;
      PULSE_INHIBIT_OUT         <= 1'b0;
      INVERTER_SHIFT_OUT        <= 1'b0;
      CONTROLLER_ENABLE_OUT     <= 1'b0;
      CONTROLLER_SET_TRACK_OUT  <= 1'b0;
      DIRECTION_ONE_OPERATIONAL <= 1'b0;
      DIRECTION_TWO_OPERATIONAL <= 1'b0;
      TEST_MODE_ACTIVE          <= 1'b0;
      ZERO_TORQUE_REQUESTED     <= 1'b0;
      DIRECTION_ONE_REQUESTED   <= 1'b0;
      DIRECTION_TWO_REQUESTED   <= 1'b0;
      FIRING_CONTROL_WORD       <= 16'h0000;
      SETPOINT_OUT              <= 16'h0000;
      CONTROLLER_SETTING_VALUE  <= 16'h0000;
    end else if (tick) begin
      CONTROL_IN_OPERATION      <= run;
      PULSE_INHIBIT_OUT         <= inhibit_now || !run;
      INVERTER_SHIFT_OUT        <= (fault_any || flt_q) && !inhibit_now;
      CONTROLLER_ENABLE_OUT     <= run;
      CONTROLLER_SET_TRACK_OUT  <= !run;
      DIRECTION_ONE_OPERATIONAL <= d1;
      DIRECTION_TWO_OPERATIONAL <= d2;
      TEST_MODE_ACTIVE          <= test_q;
      ZERO_TORQUE_REQUESTED     <= !above && zero_cnt_hit;
      DIRECTION_ONE_REQUESTED   <= d1_req;
      DIRECTION_TWO_REQUESTED   <= d2_req;
      SETPOINT_OUT              <= (d1 || d2) ? sum_sp[15:0] : 16'h0000;
      CONTROLLER_SETTING_VALUE  <= IN_WORDS.controller_setting_value;
      FIRING_CONTROL_WORD       <= '0;
      FIRING_CONTROL_WORD[CW_ON] <= run;
      FIRING_CONTROL_WORD[CW_PI] <= inhibit_now || !run;
      FIRING_CONTROL_WORD[CW_PS] <= (fault_any || flt_q) && !inhibit_now;
      FIRING_CONTROL_WORD[CW_CE] <= run;
      FIRING_CONTROL_WORD[CW_D1] <= d1;
      FIRING_CONTROL_WORD[CW_D2] <= d2;
      FIRING_CONTROL_WORD[CW_SC] <= !run;
      FIRING_CONTROL_WORD[CW_TM] <= test_q;
      FIRING_CONTROL_WORD[CW_M0] <= !above && zero_cnt_hit;
      FIRING_CONTROL_WORD[CW_M1] <= d1_req;
      FIRING_CONTROL_WORD[CW_M2] <= d2_req;
    end
  end

endmodule : tcs_switchover

/* File: verification/tcs_switchover_checker.sv */
// Port-level checker for the thyristor current switch-over block.
// Assumes outputs settle one tick after inputs, with the sample interval left at zero.
`timescale 1ns/1ps
module tcs_switchover_checker (
  // Clock and reset
  input wire logic             CLK,
  input wire logic             RST,
  // Watched ports
  input wire tcs_pkg::tcs_in_t IN_WORDS,
  input wire logic             CONTROL_IN_OPERATION,
  input wire logic             PULSE_INHIBIT_OUT,
  input wire logic             INVERTER_SHIFT_OUT,
  input wire logic             CONTROLLER_ENABLE_OUT,
  input wire logic             CONTROLLER_SET_TRACK_OUT,
  input wire logic             DIRECTION_ONE_OPERATIONAL,
  input wire logic             DIRECTION_TWO_OPERATIONAL,
  input wire logic             TEST_MODE_ACTIVE,
  input wire logic             ZERO_TORQUE_REQUESTED,
  input wire logic             DIRECTION_ONE_REQUESTED,
  input wire logic             DIRECTION_TWO_REQUESTED,
  input wire logic [15:0]      FIRING_CONTROL_WORD,
  input wire logic [15:0]      SETPOINT_OUT,
  input wire logic [15:0]      HW_MESSAGE_WORD,
  input wire logic [15:0]      ALARM_WORD_ONE,
  input wire logic [15:0]      ALARM_WORD_TWO,
  input wire logic             ALARM_SUMMARY,
  input wire logic [15:0]      FAULT_WORD_ONE,
  input wire logic [15:0]      FAULT_WORD_TWO,
  input wire logic             FAULT_SUMMARY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // Summaries follow the words they collect
  a_alarm_sum: assert property (ALARM_SUMMARY == |{ALARM_WORD_ONE, ALARM_WORD_TWO})
    else $error("alarm summary wrong");
  a_fault_sum: assert property (FAULT_SUMMARY == |{FAULT_WORD_ONE, FAULT_WORD_TWO})
    else $error("fault summary wrong");
  // Control word is the packed image of the single-bit outputs
  a_cw_pack: assert property (FIRING_CONTROL_WORD == {5'h00, DIRECTION_TWO_REQUESTED,
    DIRECTION_ONE_REQUESTED, ZERO_TORQUE_REQUESTED, TEST_MODE_ACTIVE, CONTROLLER_SET_TRACK_OUT,
    DIRECTION_TWO_OPERATIONAL, DIRECTION_ONE_OPERATIONAL, CONTROLLER_ENABLE_OUT, INVERTER_SHIFT_OUT,
    PULSE_INHIBIT_OUT, CONTROL_IN_OPERATION}) else $error("control word packing wrong");
  // A new fault stops operation within two ticks
  a_fault_stop: assert property ($rose(FAULT_SUMMARY) |-> ##[0:2] !CONTROL_IN_OPERATION)
    else $error("operation kept after fault");
  // Setpoint is held at zero with no direction operational
  a_sp_gate: assert property (!(DIRECTION_ONE_OPERATIONAL || DIRECTION_TWO_OPERATIONAL) |-> SETPOINT_OUT == 16'h0000)
    else $error("setpoint passed while not operational");
  // Masking only ever clears hardware status bits
  a_hw_gate: assert property ((HW_MESSAGE_WORD & ~$past(IN_WORDS.hw_raw)) == 16'h0000)
    else $error("hardware word bit without raw bit");
  // A fault bit needs its alarm bit
  a_fault_src: assert property (((FAULT_WORD_ONE & ~ALARM_WORD_ONE) | (FAULT_WORD_TWO & ~ALARM_WORD_TWO)) == 16'h0000)
    else $error("fault bit without alarm bit");
  // Zero torque excludes both direction requests
  a_zero_excl: assert property (ZERO_TORQUE_REQUESTED |-> !DIRECTION_ONE_REQUESTED && !DIRECTION_TWO_REQUESTED)
    else $error("zero torque with direction request");
endmodule : tcs_switchover_checker

bind tcs_switchover tcs_switchover_checker u_chk (.CLK, .RST, .IN_WORDS, .CONTROL_IN_OPERATION, .PULSE_INHIBIT_OUT,
  .INVERTER_SHIFT_OUT, .CONTROLLER_ENABLE_OUT, .CONTROLLER_SET_TRACK_OUT, .DIRECTION_ONE_OPERATIONAL,
  .DIRECTION_TWO_OPERATIONAL, .TEST_MODE_ACTIVE, .ZERO_TORQUE_REQUESTED, .DIRECTION_ONE_REQUESTED,
  .DIRECTION_TWO_REQUESTED, .FIRING_CONTROL_WORD, .SETPOINT_OUT, .HW_MESSAGE_WORD, .ALARM_WORD_ONE,
  .ALARM_WORD_TWO, .ALARM_SUMMARY, .FAULT_WORD_ONE, .FAULT_WORD_TWO, .FAULT_SUMMARY);

/* File: verification/tcs_far_model.sv */
// Model of the neighbouring controller and firing blocks feeding the switch-over logic.
// Assumes the bench sets alarm, status and setpoint levels; words change just after CLK.
`timescale 1ns/1ps
module tcs_far_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Commands from the block
  input  wire logic        set_track,
  input  wire logic        enable,
  // Levels chosen by the bench
  input  wire logic [15:0] alarm_one,
  input  wire logic [15:0] alarm_two,
  input  wire logic [15:0] hw_status,
  input  wire logic [15:0] sp_one,
  input  wire logic [15:0] sp_two,
  // Words towards the block
  output tcs_pkg::tcs_in_t words
);
  import tcs_pkg::*;
  // Controller setting value sits at a preset while tracked and ramps while enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      words <= '0;
    end else begin
      words.alarm_word_one <= alarm_one;
      words.alarm_word_two <= alarm_two;
      words.hw_raw         <= hw_status;
      words.setpoint_one   <= sp_one;
      words.setpoint_two   <= sp_two;
      if (set_track) words.controller_setting_value <= 16'h0100;
      else if (enable) words.controller_setting_value <= words.controller_setting_value + 16'h0001;
    end
  end
endmodule : tcs_far_model

/* File: verification/tb.sv */
// Self-checking bench for the switch-over block, driven over its register bus.
// Assumes shortened counts: ZT_CYCLES 20 and MS_CNT 4.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, a); end end
module tb;
  import tcs_pkg::*;
  logic        clk = 1'b0, rst = 1'b1, ce = 1'b1, rd = 1'b0, wr = 1'b0, wt;
  logic [5:0]  adr = 6'h00;
  logic [31:0] wd = 32'h0, rdat, q;
  logic [15:0] al1 = 16'h0, al2 = 16'h0, hw = 16'h0, sp1 = 16'h0;
  logic [15:0] fcw, spo, csv, hwm, aw1, aw2, fw1, fw2;
  logic        op, pi, ps, cen, cst, d1, d2, tm, zt, r1, r2, asum, fsum;
  tcs_in_t     in_w;
  tcs_diag_t   diag;
  int          fail_count = 0, n_compared = 0, cyc = 0;
  logic [15:0] rv [9] = '{16'h0000, 16'h0000, 16'h067e, 16'hffff, 16'hffff, 16'hffff, 16'h0029, 16'h0064, 16'h0000};
  // Clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  tcs_far_model u_far (.clk(clk), .rst(rst), .set_track(cst), .enable(cen), .alarm_one(al1), .alarm_two(al2),
    .hw_status(hw), .sp_one(sp1), .sp_two(16'h0000), .words(in_w));
  tcs_switchover #(.ZT_CYCLES(20), .MS_CNT(4)) u_dut (.CLK(clk), .RST(rst), .CE(ce), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(4'h3), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wt), .IN_WORDS(in_w), .CONTROL_IN_OPERATION(op), .PULSE_INHIBIT_OUT(pi),
    .INVERTER_SHIFT_OUT(ps), .CONTROLLER_ENABLE_OUT(cen), .CONTROLLER_SET_TRACK_OUT(cst),
    .DIRECTION_ONE_OPERATIONAL(d1), .DIRECTION_TWO_OPERATIONAL(d2), .TEST_MODE_ACTIVE(tm),
    .ZERO_TORQUE_REQUESTED(zt), .DIRECTION_ONE_REQUESTED(r1), .DIRECTION_TWO_REQUESTED(r2),
    .FIRING_CONTROL_WORD(fcw), .SETPOINT_OUT(spo), .CONTROLLER_SETTING_VALUE(csv), .HW_MESSAGE_WORD(hwm),
    .ALARM_WORD_ONE(aw1), .ALARM_WORD_TWO(aw2), .ALARM_SUMMARY(asum), .FAULT_WORD_ONE(fw1),
    .FAULT_WORD_TWO(fw2), .FAULT_SUMMARY(fsum), .DIAG(diag));
  // Verdict and end of run
  task automatic stop_test();
    if (fail_count == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : stop_test
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
  end
  // One bus cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [3:0] idx, input logic [15:0] d);
    @(posedge clk);
    adr <= {idx, 2'b00};
    rd  <= ~w;
    wr  <= w;
    wd  <= {16'h0000, d};
    do @(posedge clk); while (wt !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input string nm, input logic [3:0] idx, input logic [15:0] e);
    bus(1'b0, idx, 16'h0000);
    `CHK(nm, e, q[15:0])
  endtask : rchk
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // Acknowledge with switch-on low, then a fresh switch-on edge
  task automatic restart();
    bus(1'b1, REG_CTRL, 16'h0000);
    bus(1'b1, REG_CTRL, 16'h0002);
    bus(1'b1, REG_CTRL, 16'h0000);
    bus(1'b1, REG_CTRL, 16'h0001);
    tk(6);
  endtask : restart
  // Main sequence
  initial begin
    tk(3);
    `CHK("fcw_rst", 16'h0000, fcw)
    `CHK("diag_rst", 32'h0, diag)
    `CHK("out_rst", 4'h0, {ps, cen, cst, op})
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) rchk("reg_rst", 4'(i + 2), rv[i]);
    rchk("unmapped", 4'he, 16'h0000);
    tk(4);
    `CHK("sv_track", 16'h0100, csv)
    al2 <= 16'h0003;
    tk(4);
    `CHK("fw2", 16'h0003, fw2)
    `CHK("fsum", 1'b1, fsum)
    `CHK("shift", 1'b1, ps)
    bus(1'b1, REG_INHIB2, 16'h0002);
    tk(4);
    `CHK("inh2", 2'b10, {pi, ps})
    bus(1'b1, REG_FEN2, 16'h0001);
    tk(4);
    `CHK("fw2_mask", 16'h0001, fw2)
    al2 <= 16'h0000;
    al1 <= 16'hffff;
    hw  <= 16'hffff;
    bus(1'b1, REG_CTRL, 16'h0008);
    bus(1'b1, REG_INHIB1, 16'h0080);
    tk(4);
    `CHK("fw1_sup", 16'hf981, fw1)
    `CHK("aw_sup", 32'hf9810000, {aw1, aw2})
    `CHK("hw_sup", 16'hf981, hwm)
    `CHK("inh1", 2'b10, {pi, ps})
    `CHK("asum", 1'b1, asum)
    bus(1'b1, REG_HWEN, 16'h00ff);
    tk(4);
    `CHK("hw_en", 16'h0081, hwm)
    al1 <= 16'h0000;
    hw  <= 16'h0000;
    sp1 <= 16'h1000;
    restart();
    `CHK("run", 4'b1110, {op, cen, d1, d2})
    `CHK("sp_pass", 16'h1000, spo)
    `CHK("req", 3'b010, {zt, r1, r2})
    `CHK("cw_run", 16'h0219, fcw)
    bus(1'b1, REG_CTRL, 16'h0005);
    tk(4);
    `CHK("cw_test", 16'h0299, fcw)
    bus(1'b1, REG_CMD, 16'h0003);
    tk(4);
    `CHK("contra", 1'b0, op)
    bus(1'b1, REG_CMD, 16'h0000);
    restart();
    al2 <= 16'h0001;
    tk(4);
    `CHK("flt_off", 1'b0, op)
    al2 <= 16'h0000;
    bus(1'b1, REG_CTRL, 16'h0003);
    bus(1'b1, REG_CTRL, 16'h0000);
    bus(1'b1, REG_CTRL, 16'h0001);
    tk(6);
    `CHK("ack_refused", 1'b0, op)
    restart();
    `CHK("restart", 1'b1, op)
    bus(1'b1, REG_STOPST, 16'h000b);
    restart();
    al2 <= 16'h0001;
    tk(4);
    `CHK("halt", 32'h011e0b0b, diag)
    al2 <= 16'h0000;
    sp1 <= 16'h0000;
    bus(1'b1, REG_STOPST, 16'h0064);
    tk(40);
    `CHK("zero_torque", 1'b1, zt)
    // Two-millisecond sampling: words only move on the eighth clock after the write
    bus(1'b1, REG_SAMPLE, 16'h0002);
    hw <= 16'h0001;
    tk(4);
    `CHK("slow_hold", 16'h0000, hwm)
    tk(6);
    `CHK("slow_tick", 16'h0001, hwm)
    bus(1'b1, REG_SAMPLE, 16'h0000);
    // Enable low freezes the outputs
    ce  <= 1'b0;
    sp1 <= 16'h1000;
    tk(4);
    `CHK("ce_freeze", 1'b1, zt)
    ce <= 1'b1;
    tk(4);
    `CHK("ce_run", 1'b0, zt)
    stop_test();
  end
endmodule : tb
